// [psc_map.svh]
// Constants for the power-up strap loader: pin positions, decoded values, timing.
// Assumes inclusion by bare name from the package and the design file.
// Overview of operation
// RL1: Clock mode strap selects common or separate clocking.
// RL2: Frequency strap decodes 125, 100, 156.25 MHz.
// RL3: 100 MHz reference allows 1.25/2.5/5 Gbaud.
// RL4: 125/156.25 MHz allows 1.25/2.5/3 Gbaud.
// RL5: Any legal reference allows PCIe 2.5/5.
// RL6: Load inhibit strap blocks EEPROM boot load.
// RL7: Width strap picks one or two address bytes.
// RL8: Without EEPROM, width strap names boot agent.
// RL9: Four slave address straps form slave address.
// RL10: Software may replace strapped slave address.
// RL11: Address select gives EEPROM address 10100 plus straps.
// RL12: Select low forces low EEPROM bits 00.
// RL13: Host strap: id LSB from id strap.
// RL14: Slave with id strap high: all ones.
// RL15: Slave with id strap low: FE values.
// RL16: Host role bit loads from host strap.
// RL17: Receive swap strap gives 00 or 10.
// RL18: Straps share GPIO bits at fixed positions.
// RL19: Board holds straps 4000 cycles after reset.
// RL20: Frequency select comes from GPIO 12:11.
// RL21: Capture straps once; derive everything from copies.
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH

`define PSC_GPIO_W        16
`define PSC_SA_HI         3
`define PSC_SA_LO         0
`define PSC_INHIBIT_BIT   4
`define PSC_ADDR_SEL_BIT  5
`define PSC_ADDR_W_BIT    6
`define PSC_RX_SWAP_BIT   7
`define PSC_HOST_BIT      9
`define PSC_ID_BIT        10
`define PSC_FREQ_HI       12
`define PSC_FREQ_LO       11

`define PSC_FREQ_125      2'h3
`define PSC_FREQ_100      2'h2
`define PSC_FREQ_156      2'h1
`define PSC_FREQ_RSVD     2'h0

// Rate masks, bit order 1.25/2.5/3/5 Gbaud
`define PSC_RIO_R100      4'hB
`define PSC_RIO_RLOW      4'h7
`define PSC_PCIE_RATES    4'hA
`define PSC_NO_RATES      4'h0

`define PSC_EE_ADDR_TOP   5'h14
`define PSC_LOW_ZERO      2'h0
`define PSC_ID8_SLAVE     8'hFE
`define PSC_ID16_SLAVE    16'h00FE
`define PSC_ID8_ONES      8'hFF
`define PSC_ID16_ONES     16'hFFFF
`define PSC_SWAP_ON       2'h2
`define PSC_SWAP_OFF      2'h0

`define PSC_HOLD_CYCLES   4000

`endif

// [psc_pkg.sv]
// Types for the power-up strap loader.
// Assumes psc_map.svh is reachable by bare name.
`include "psc_map.svh"
package psc_pkg;
  typedef enum logic [1:0] {
    PSC_REF_RESERVED,
    PSC_REF_100,
    PSC_REF_125,
    PSC_REF_156
  } psc_ref_t;

  // Serdes rate capability flags, bit order 1.25/2.5/3/5 Gbaud
  typedef logic [3:0] psc_rates_t;

  typedef enum logic [1:0] {
    PSC_WAIT,
    PSC_DONE
  } psc_state_t;
endpackage

// [psc_strap_loader.sv]
// Power-up strap loader: samples shared GPIO straps after reset release
// and holds the derived configuration and register reset values.
// Assumes straps are synchronous to clock and held static by the board.
`timescale 1ns/100ps
`default_nettype none
`include "psc_map.svh"

module psc_strap_loader #(
  parameter int HOLD_CYCLES = `PSC_HOLD_CYCLES
) (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic [`PSC_GPIO_W-1:0]   gpio_in,
  input  wire logic                     pcie_clocking_mode_strap,
  input  wire logic                     slave_addr_wr,
  input  wire logic [6:0]               slave_addr_wdata,
  input  wire logic                     eeprom_addr_wr,
  input  wire logic [6:0]               eeprom_addr_wdata,
  output var  logic                     straps_valid,
  output var  logic                     pcie_common_clock,
  output var  psc_pkg::psc_ref_t        ref_freq,
  output var  psc_pkg::psc_rates_t      rio_rates,
  output var  psc_pkg::psc_rates_t      pcie_rates,
  output var  logic                     eeprom_load_en,
  output var  logic                     eeprom_two_byte,
  output var  logic                     boot_by_i2c_master,
  output var  logic [6:0]               i2c_slave_addr,
  output var  logic [6:0]               eeprom_addr,
  output var  logic                     rio_host,
  output var  logic [7:0]               base_device_id,
  output var  logic [15:0]              large_base_device_id,
  output var  logic [1:0]               rx_lane_swap
);
  import psc_pkg::*;

  localparam int CW = $clog2(HOLD_CYCLES + 1);

  // Map two strap bits to a reference frequency
  function automatic psc_ref_t decode_ref(input logic [1:0] s);
    psc_ref_t r;
    r = PSC_REF_RESERVED;
    if (s == `PSC_FREQ_125) begin
      r = PSC_REF_125;
    end else if (s == `PSC_FREQ_100) begin
      r = PSC_REF_100;
    end else if (s == `PSC_FREQ_156) begin
      r = PSC_REF_156;
    end
    return r;
  endfunction

  psc_state_t              state_reg;
  psc_state_t              state_next;
  logic [CW-1:0]           count_reg;
  logic [CW-1:0]           count_next;
  logic [`PSC_GPIO_W-1:0]  held_reg;
  logic [`PSC_GPIO_W-1:0]  held_next;
  logic                    clkmode_reg;
  logic                    clkmode_next;
  logic                    window_end;

  // Stability window counter; straps are only trusted at its end
  assign window_end = (state_reg == PSC_WAIT) && (count_reg == CW'(HOLD_CYCLES - 1)); // RL19

  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      PSC_WAIT: begin
        count_next = count_reg + CW'(1);
        if (window_end) begin
          state_next = PSC_DONE;
        end
      end
      PSC_DONE: begin
        count_next = count_reg;
      end
      default: begin
        state_next = PSC_WAIT;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PSC_WAIT;
      count_reg <= '0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // One-time capture; later pin activity is ignored as GPIO traffic
  assign held_next    = window_end ? gpio_in : held_reg; // RL21 RL18
  assign clkmode_next = window_end ? pcie_clocking_mode_strap : clkmode_reg; // RL1

  // Zero until capture, so outputs carry the all-zero strap decode through the window
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      held_reg    <= '0;
      clkmode_reg <= 1'b0;
    end else begin
      held_reg    <= held_next;
      clkmode_reg <= clkmode_next;
    end
  end

  // Decoded views of the held copies
  wire logic [1:0] freq_bits  = held_reg[`PSC_FREQ_HI:`PSC_FREQ_LO]; // RL20
  wire psc_ref_t   ref_dec    = decode_ref(freq_bits); // RL2
  wire logic       inhibit    = held_reg[`PSC_INHIBIT_BIT]; // RL6
  wire logic       width_bit  = held_reg[`PSC_ADDR_W_BIT];
  wire logic       sel_bit    = held_reg[`PSC_ADDR_SEL_BIT];
  wire logic       host_bit   = held_reg[`PSC_HOST_BIT];
  wire logic       id_bit     = held_reg[`PSC_ID_BIT];
  wire logic [3:0] sa_bits    = held_reg[`PSC_SA_HI:`PSC_SA_LO];

  // Rate capability: bit0 1.25, bit1 2.5, bit2 3, bit3 5 Gbaud
  wire psc_rates_t rio_dec  = (ref_dec == PSC_REF_100) ? `PSC_RIO_R100 : // RL3
                              (ref_dec == PSC_REF_RESERVED) ? `PSC_NO_RATES : `PSC_RIO_RLOW; // RL4
  wire psc_rates_t pcie_dec = (ref_dec == PSC_REF_RESERVED) ? `PSC_NO_RATES : `PSC_PCIE_RATES; // RL5

  // Upper slave address bits are zero; only four are strapped
  wire logic [6:0] sa_strap = {3'h0, sa_bits}; // RL9
  wire logic [1:0] ee_low   = sel_bit ? sa_bits[1:0] : `PSC_LOW_ZERO; // RL11 RL12
  wire logic [6:0] ee_strap = {`PSC_EE_ADDR_TOP, ee_low}; // RL11

  wire logic [7:0]  id8  = host_bit ? {7'h00, id_bit} : // RL13
                           id_bit ? `PSC_ID8_ONES : `PSC_ID8_SLAVE; // RL14 RL15
  wire logic [15:0] id16 = host_bit ? {15'h0000, id_bit} : // RL13
                           id_bit ? `PSC_ID16_ONES : `PSC_ID16_SLAVE; // RL14 RL15

  // Outputs load one cycle after capture, with straps_valid; software overrides afterwards
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      straps_valid <= 1'b0;
    end else begin
      straps_valid <= (state_reg == PSC_DONE);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pcie_common_clock    <= 1'b0;
      ref_freq             <= PSC_REF_RESERVED;
      rio_rates            <= '0;
      pcie_rates           <= '0;
      eeprom_load_en       <= 1'b0;
      eeprom_two_byte      <= 1'b0;
      boot_by_i2c_master   <= 1'b0;
      rio_host             <= 1'b0;
      base_device_id       <= '0;
      large_base_device_id <= '0;
      rx_lane_swap         <= `PSC_SWAP_OFF;
    end else begin
      pcie_common_clock    <= clkmode_reg; // RL1
      ref_freq             <= ref_dec; // RL2
      rio_rates            <= rio_dec;
      pcie_rates           <= pcie_dec;
      eeprom_load_en       <= (state_reg == PSC_DONE) && !inhibit; // RL6
      eeprom_two_byte      <= !inhibit && width_bit; // RL7
      boot_by_i2c_master   <= inhibit && width_bit; // RL8
      rio_host             <= host_bit; // RL16
      base_device_id       <= id8;
      large_base_device_id <= id16;
      rx_lane_swap         <= held_reg[`PSC_RX_SWAP_BIT] ? `PSC_SWAP_ON : `PSC_SWAP_OFF; // RL17
    end
  end

  // Addresses: strapped until software writes, then the written value wins
  // Writes before capture are dropped, since the strap load would clobber them
  logic       sa_over_reg;
  logic       sa_over_next;
  logic       ee_over_reg;
  logic       ee_over_next;
  logic [6:0] sa_addr_next;
  logic [6:0] ee_addr_next;
  wire logic  sa_take = slave_addr_wr && (state_reg == PSC_DONE); // RL10
  wire logic  ee_take = eeprom_addr_wr && (state_reg == PSC_DONE); // RL12

  assign sa_over_next = sa_over_reg || sa_take;
  assign ee_over_next = ee_over_reg || ee_take;
  assign sa_addr_next = sa_take ? slave_addr_wdata : (sa_over_reg ? i2c_slave_addr : sa_strap); // RL9 RL10
  assign ee_addr_next = ee_take ? eeprom_addr_wdata : (ee_over_reg ? eeprom_addr : ee_strap); // RL11 RL12

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sa_over_reg    <= 1'b0;
      ee_over_reg    <= 1'b0;
      i2c_slave_addr <= '0;
      eeprom_addr    <= '0;
    end else begin
      sa_over_reg    <= sa_over_next;
      ee_over_reg    <= ee_over_next;
      i2c_slave_addr <= sa_addr_next;
      eeprom_addr    <= ee_addr_next;
    end
  end

  // Helper: cycles since reset release, saturating just past the window
  logic [CW:0] since_reg;
  logic [CW:0] since_next;
  assign since_next = (since_reg <= (CW+1)'(HOLD_CYCLES)) ? since_reg + (CW+1)'(1) : since_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      since_reg <= '0;
    end else begin
      since_reg <= since_next;
    end
  end

  capture_time_a: assert property (@(posedge clock) disable iff (!rst_n) // RL19
    window_end |-> since_reg == (CW+1)'(HOLD_CYCLES - 1))
    else $error("strap capture at wrong cycle");

  frozen_held_a: assert property (@(posedge clock) disable iff (!rst_n) // RL21
    (state_reg == PSC_DONE) |=> $stable(held_reg))
    else $error("held straps changed after capture");

  clock_mode_a: assert property (@(posedge clock) disable iff (!rst_n) // RL1
    straps_valid |-> pcie_common_clock == clkmode_reg)
    else $error("clock mode not from strap");

  freq_decode_a: assert property (@(posedge clock) disable iff (!rst_n) // RL2
    straps_valid && freq_bits == `PSC_FREQ_100 |-> ref_freq == PSC_REF_100 && rio_rates == `PSC_RIO_R100)
    else $error("100 MHz decode wrong");

  eeprom_mode_a: assert property (@(posedge clock) disable iff (!rst_n) // RL6
    straps_valid |-> eeprom_load_en == !inhibit && !(eeprom_two_byte && boot_by_i2c_master))
    else $error("eeprom load enable wrong");

  ee_address_a: assert property (@(posedge clock) disable iff (!rst_n) // RL11
    straps_valid && !ee_over_reg |-> eeprom_addr[6:2] == `PSC_EE_ADDR_TOP &&
      (sel_bit || eeprom_addr[1:0] == `PSC_LOW_ZERO))
    else $error("eeprom address wrong");

  slave_ids_a: assert property (@(posedge clock) disable iff (!rst_n) // RL15
    straps_valid && !host_bit && !id_bit |-> base_device_id == `PSC_ID8_SLAVE &&
      large_base_device_id == `PSC_ID16_SLAVE)
    else $error("slave base_device_id wrong");

  host_ids_a: assert property (@(posedge clock) disable iff (!rst_n) // RL13
    straps_valid && host_bit |-> base_device_id == {7'h00, id_bit} && rio_host)
    else $error("host base_device_id wrong");

  swap_field_a: assert property (@(posedge clock) disable iff (!rst_n) // RL17
    straps_valid |-> rx_lane_swap == (held_reg[`PSC_RX_SWAP_BIT] ? `PSC_SWAP_ON : `PSC_SWAP_OFF))
    else $error("rx swap field wrong");

  sa_override_a: assert property (@(posedge clock) disable iff (!rst_n) // RL10
    slave_addr_wr && state_reg == PSC_DONE |=> i2c_slave_addr == $past(slave_addr_wdata))
    else $error("slave address override lost");

  // Window and capture checks
  valid_rise_a: assert property (@(posedge clock) disable iff (!rst_n) // RL19
    $rose(straps_valid) |-> since_reg == (CW+1)'(HOLD_CYCLES + 1))
    else $error("straps valid at wrong cycle");

  capture_once_a: assert property (@(posedge clock) disable iff (!rst_n) // RL19
    window_end |=> !window_end)
    else $error("strap capture repeated");

  state_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RL21
    state_reg == PSC_DONE |=> state_reg == PSC_DONE)
    else $error("loader left done state");

  // Pins go busy after the window; settings must not follow them
  settings_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RL21
    straps_valid |=> $stable(pcie_common_clock) && $stable(ref_freq) && $stable(base_device_id) &&
      $stable(large_base_device_id) && $stable(rx_lane_swap) && $stable(rio_host))
    else $error("settings moved after capture");

  // Frequency and rate checks
  freq_125_a: assert property (@(posedge clock) disable iff (!rst_n) // RL2
    straps_valid && freq_bits == `PSC_FREQ_125 |-> ref_freq == PSC_REF_125)
    else $error("125 MHz decode wrong");

  freq_156_a: assert property (@(posedge clock) disable iff (!rst_n) // RL2
    straps_valid && freq_bits == `PSC_FREQ_156 |-> ref_freq == PSC_REF_156)
    else $error("156.25 MHz decode wrong");

  freq_reserved_a: assert property (@(posedge clock) disable iff (!rst_n) // RL2
    straps_valid && freq_bits == `PSC_FREQ_RSVD |-> ref_freq == PSC_REF_RESERVED &&
      rio_rates == `PSC_NO_RATES && pcie_rates == `PSC_NO_RATES)
    else $error("reserved frequency decode wrong");

  rio_low_rates_a: assert property (@(posedge clock) disable iff (!rst_n) // RL4
    straps_valid && (freq_bits == `PSC_FREQ_125 || freq_bits == `PSC_FREQ_156) |->
      rio_rates == `PSC_RIO_RLOW)
    else $error("rapidio rates wrong");

  pcie_rates_a: assert property (@(posedge clock) disable iff (!rst_n) // RL5
    straps_valid && freq_bits != `PSC_FREQ_RSVD |-> pcie_rates == `PSC_PCIE_RATES)
    else $error("pcie rates wrong");

  // Boot mode checks
  no_load_wait_a: assert property (@(posedge clock) disable iff (!rst_n) // RL6
    state_reg == PSC_WAIT |=> !eeprom_load_en)
    else $error("eeprom load before capture");

  two_byte_a: assert property (@(posedge clock) disable iff (!rst_n) // RL7
    straps_valid |-> eeprom_two_byte == (eeprom_load_en && width_bit))
    else $error("eeprom address width wrong");

  boot_agent_a: assert property (@(posedge clock) disable iff (!rst_n) // RL8
    straps_valid |-> boot_by_i2c_master == (!eeprom_load_en && width_bit))
    else $error("boot agent wrong");

  // Address checks
  slave_strap_a: assert property (@(posedge clock) disable iff (!rst_n) // RL9
    straps_valid && !sa_over_reg |-> i2c_slave_addr == {3'h0, sa_bits})
    else $error("strapped slave address wrong");

  ee_select_a: assert property (@(posedge clock) disable iff (!rst_n) // RL11
    straps_valid && !ee_over_reg && sel_bit |-> eeprom_addr[1:0] == sa_bits[1:0])
    else $error("eeprom low bits not from straps");

  ee_default_a: assert property (@(posedge clock) disable iff (!rst_n) // RL12
    straps_valid && !ee_over_reg && !sel_bit |-> eeprom_addr[1:0] == `PSC_LOW_ZERO)
    else $error("eeprom low bits not zero");

  ee_override_a: assert property (@(posedge clock) disable iff (!rst_n) // RL12
    eeprom_addr_wr && state_reg == PSC_DONE |=> eeprom_addr == $past(eeprom_addr_wdata))
    else $error("eeprom address override lost");

  early_refuse_a: assert property (@(posedge clock) disable iff (!rst_n) // RL10
    state_reg == PSC_WAIT |-> !sa_over_reg && !ee_over_reg)
    else $error("write taken before capture");

  // Identity checks
  ones_ids_a: assert property (@(posedge clock) disable iff (!rst_n) // RL14
    straps_valid && !host_bit && id_bit |-> base_device_id == `PSC_ID8_ONES &&
      large_base_device_id == `PSC_ID16_ONES)
    else $error("all ones base_device_id wrong");

  host_large_a: assert property (@(posedge clock) disable iff (!rst_n) // RL13
    straps_valid && host_bit |-> large_base_device_id == {15'h0000, id_bit})
    else $error("host large base_device_id wrong");

  host_role_a: assert property (@(posedge clock) disable iff (!rst_n) // RL16
    straps_valid |-> rio_host == host_bit)
    else $error("host role wrong");

endmodule
`default_nettype wire

// [psc_board_model.sv]
// Board strap model: drives the shared GPIO straps and the clock mode pin.
// Assumes the loader samples once; pins go busy after the stable window.
`timescale 1ns/100ps
`default_nettype none
module psc_board_model #(
  parameter int HOLD_CYCLES = 8
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [15:0] strap_cfg,
  input  wire logic        mode_cfg,
  output var  logic [15:0] gpio_in,
  output var  logic        clk_mode_pin
);
  logic [7:0] cnt_reg;
  logic       stable;
  // Edges since reset release, saturating
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) cnt_reg <= 8'h00;
    else if (cnt_reg != 8'hFF) cnt_reg <= cnt_reg + 8'h01;
  end
  // Held only through the window, then reused as GPIO with a toggling pattern
  assign stable = cnt_reg <= 8'(HOLD_CYCLES);
  assign gpio_in = stable ? strap_cfg : (cnt_reg[0] ? ~strap_cfg : strap_cfg ^ 16'h5A5A);
  assign clk_mode_pin = stable ? mode_cfg : cnt_reg[0];
endmodule
`default_nettype wire

// [psc_strap_loader_tb_top.sv]
// Testbench for the strap loader: boots several strap sets, then overrides.
// Assumes psc_pkg and psc_map.svh compiled first.
`timescale 1ns/100ps
`default_nettype none
module psc_strap_loader_tb_top;
  import psc_pkg::*;
  localparam int HOLD = 8;
  logic clock = 1'b0, rst_n = 1'b0, sa_wr = 1'b0, ee_wr = 1'b0, mode = 1'b0;
  logic [6:0] sa_wd = 7'h00, ee_wd = 7'h00, sa, ea;
  logic [15:0] cfg = 16'h0000, gpio, lid;
  logic pin_m, vld, pcc, ld, two, bim, host;
  logic [7:0] bid;
  logic [1:0] swp;
  psc_ref_t rf;
  psc_rates_t rr, pr;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  // Entries are {clock mode, gpio image}
  logic [16:0] tbl [4] = '{17'h11865, 17'h016DA, 17'h10A1F, 17'h00403};

  psc_board_model #(.HOLD_CYCLES(HOLD)) i_psc_board_model (.clock(clock), .rst_n(rst_n),
    .strap_cfg(cfg), .mode_cfg(mode), .gpio_in(gpio), .clk_mode_pin(pin_m));
  psc_strap_loader #(.HOLD_CYCLES(HOLD)) i_psc_strap_loader (.clock(clock), .rst_n(rst_n),
    .gpio_in(gpio), .pcie_clocking_mode_strap(pin_m), .slave_addr_wr(sa_wr),
    .slave_addr_wdata(sa_wd), .eeprom_addr_wr(ee_wr), .eeprom_addr_wdata(ee_wd),
    .straps_valid(vld), .pcie_common_clock(pcc), .ref_freq(rf), .rio_rates(rr),
    .pcie_rates(pr), .eeprom_load_en(ld), .eeprom_two_byte(two), .boot_by_i2c_master(bim),
    .i2c_slave_addr(sa), .eeprom_addr(ea), .rio_host(host), .base_device_id(bid),
    .large_base_device_id(lid), .rx_lane_swap(swp));

  always #12.5 clock = ~clock;
  // Hang guard: about 81 cycles are needed
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Software address write: strobes stand over one edge, then settle time
  task automatic sw_write(input logic s, input logic [6:0] sv, input logic e, input logic [6:0] ev);
    sa_wr = s;
    sa_wd = sv;
    ee_wr = e;
    ee_wd = ev;
    @(posedge clock);
    #2;
  endtask

  // Reset, boot one strap set, early write ignored, check decode after pins go busy
  task automatic boot(input logic [15:0] g, input logic m, input bit early);
    int n;
    logic [1:0] f;
    psc_ref_t er;
    f = g[12:11];
    er = f == 2'h3 ? PSC_REF_125 : f == 2'h2 ? PSC_REF_100 : f == 2'h1 ? PSC_REF_156 : PSC_REF_RESERVED;
    @(posedge clock);
    #2 rst_n = 1'b0;
    cfg = g;
    mode = m;
    repeat (2) @(posedge clock);
    #2 rst_n = 1'b1;
    for (n = 1; n < 40 && vld !== 1'b1; n++) begin
      @(posedge clock);
      #2 sa_wr = early && n == 2;
      ee_wr = early && n == 2;
      sa_wd = 7'h7F;
      ee_wd = 7'h7F;
    end
    chk("valid_edge", 16'(n - 1), 16'(HOLD + 1));
    repeat (4) @(posedge clock);
    #2;
    chk("common_clk", {15'h0, pcc}, {15'h0, m});
    chk("ref_freq", {14'h0, rf}, {14'h0, er});
    chk("rio_rates", {12'h0, rr}, f == 2'h2 ? 16'h000B : f == 2'h0 ? 16'h0000 : 16'h0007);
    chk("pcie_rates", {12'h0, pr}, f == 2'h0 ? 16'h0000 : 16'h000A);
    chk("load_en", {15'h0, ld}, {15'h0, !g[4]});
    chk("two_byte", {15'h0, two}, {15'h0, !g[4] && g[6]});
    chk("boot_i2c", {15'h0, bim}, {15'h0, g[4] && g[6]});
    chk("slave_addr", {9'h0, sa}, {12'h0, g[3:0]});
    chk("eeprom_addr", {9'h0, ea}, {9'h0, 5'h14, g[5] ? g[1:0] : 2'h0});
    chk("host", {15'h0, host}, {15'h0, g[9]});
    chk("base_device_id", {8'h0, bid}, g[9] ? {15'h0, g[10]} : g[10] ? 16'h00FF : 16'h00FE);
    chk("large_id", lid, g[9] ? {15'h0, g[10]} : g[10] ? 16'hFFFF : 16'h00FE);
    chk("rx_swap", {14'h0, swp}, g[7] ? 16'h0002 : 16'h0000);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    foreach (tbl[i]) boot(tbl[i][15:0], tbl[i][16], i == 0);
    // Back to back software writes replace the strapped addresses
    sw_write(1'b1, 7'h55, 1'b1, 7'h2B);
    chk("sw_slave", {9'h0, sa}, 16'h0055);
    chk("sw_eeprom", {9'h0, ea}, 16'h002B);
    sw_write(1'b1, 7'h2A, 1'b0, 7'h2B);
    sa_wr = 1'b0;
    repeat (3) @(posedge clock);
    #2 chk("sw_slave2", {9'h0, sa}, 16'h002A);
    chk("sw_eeprom2", {9'h0, ea}, 16'h002B);
    end_sim();
  end
endmodule
`default_nettype wire
